// ### rtl/frds_read_seq.sv
// Execution sequencer of the read data and read deleted data commands.
`timescale 1ns/1ps
`include "frds_defs.svh"
module frds_read_seq #(
   parameter int TICK_CYCLES = `FRDS_TICK_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire frds_pkg::frds_byte_t cmd_byte_i,
   input wire logic implied_seek_en_i,
   input wire frds_pkg::frds_byte_t settle_time_i,
   input wire frds_pkg::frds_byte_t unload_time_i,
   output logic seek_req_o,
   output frds_pkg::frds_byte_t seek_cyl_o,
   input wire logic seek_done_i,
   input wire logic seek_fail_i,
   input wire frds_pkg::frds_byte_t seek_fail_cyl_i,
   output logic [3:0] drive_busy_o,
   output logic head_load_o,
   output logic cmd_busy_o,
   input wire logic hole_pulse_n_i,
   input wire logic id_valid_i,
   input wire frds_pkg::frds_byte_t id_cyl_i,
   input wire frds_pkg::frds_byte_t id_head_i,
   input wire frds_pkg::frds_byte_t id_sector_i,
   input wire frds_pkg::frds_byte_t id_size_i,
   input wire logic id_crc_ok_i,
   input wire logic dam_valid_i,
   input wire logic dam_deleted_i,
   input wire logic disk_byte_valid_i,
   input wire frds_pkg::frds_byte_t disk_byte_i,
   input wire logic data_crc_valid_i,
   input wire logic data_crc_ok_i,
   input wire logic transfer_stop_i,
   output logic fifo_valid_o,
   output frds_pkg::frds_byte_t fifo_data_o,
   output logic fifo_result_o,
   input wire logic fifo_ready_i
);
   import frds_pkg::*;

   frds_byte_t cmd [0:8];
   logic cmd_ready;
   logic deliver;
   logic last_byte;
   logic is_read;
   logic deleted_op;
   logic cm_hit;
   logic fifo_free;
   logic start_head;
   logic do_advance;
   logic idx_fall;

   frds_state_t state_reg, state_next;
   frds_byte_t c_reg, c_next, h_reg, h_next, r_reg, r_next;
   logic [1:0] ic_reg, ic_next, idx_reg, idx_next;
   logic se_reg, se_next, en_reg, en_next, de_reg, de_next, nd_reg, nd_next;
   logic cm_reg, cm_next, dd_reg, dd_next;
   logic matched_reg, matched_next, cm_stop_reg, cm_stop_next;
   logic stopped_reg, stopped_next, hole_prev_reg, hole_prev_next;
   logic [16:0] timer_reg, timer_next;
   logic [2:0] res_reg, res_next;
   logic seek_req_reg, seek_req_next, busy_reg, busy_next;
   logic head_reg, head_next;
   logic [3:0] dbusy_reg, dbusy_next;
   logic fv_reg, fv_next, fres_reg, fres_next;
   frds_byte_t fd_reg, fd_next;

   frds_cmd_loader u_loader (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .busy_i(busy_reg),
      .cmd_valid_i(cmd_valid_i),
      .cmd_byte_i(cmd_byte_i),
      .cmd_ready_o(cmd_ready),
      .cmd_o(cmd)
   );

   frds_sector_counter u_counter (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .clear_i(state_reg != st_data),
      .byte_i(state_reg == st_data && disk_byte_valid_i),
      .size_code_i(cmd[5][2:0]),
      .short_len_i(cmd[8]),
      .deliver_o(deliver),
      .last_o(last_byte),
      .beyond_short_o()
   );

   function automatic frds_byte_t result_byte(input logic [2:0] idx, input frds_byte_t st0,
                                              input frds_byte_t st1, input frds_byte_t st2,
                                              input frds_byte_t c, input frds_byte_t h,
                                              input frds_byte_t r, input frds_byte_t n);
      case (idx)
         3'h0: result_byte = st0;
         3'h1: result_byte = st1;
         3'h2: result_byte = st2;
         3'h3: result_byte = c;
         3'h4: result_byte = h;
         3'h5: result_byte = r;
         default: result_byte = n;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   frds_byte_t st0, st1, st2;

   always_comb
   begin
      st0 = 8'h00;
      st0[7:6] = ic_reg;
      st0[`FRDS_ST0_SE] = se_reg;
      st0[`FRDS_ST0_HEAD] = cmd[1][`FRDS_B1_HEAD];
      st0[1:0] = cmd[1][1:0];
      st1 = 8'h00;
      st1[`FRDS_ST1_EN] = en_reg;
      st1[`FRDS_ST1_DE] = de_reg;
      st1[`FRDS_ST1_ND] = nd_reg;
      st2 = 8'h00;
      st2[`FRDS_ST2_CM] = cm_reg;
      st2[`FRDS_ST2_DD] = dd_reg;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_next = state_reg;
      c_next = c_reg;
      h_next = h_reg;
      r_next = r_reg;
      ic_next = ic_reg;
      idx_next = idx_reg;
      se_next = se_reg;
      en_next = en_reg;
      de_next = de_reg;
      nd_next = nd_reg;
      cm_next = cm_reg;
      dd_next = dd_reg;
      matched_next = matched_reg;
      cm_stop_next = cm_stop_reg;
      stopped_next = stopped_reg;
      timer_next = timer_reg;
      res_next = res_reg;
      seek_req_next = 1'b0;
      busy_next = busy_reg;
      head_next = head_reg;
      dbusy_next = dbusy_reg;
      fv_next = fv_reg && !fifo_ready_i;
      fd_next = fd_reg;
      fres_next = fres_reg;
      fifo_free = !fv_reg || fifo_ready_i;
      hole_prev_next = hole_pulse_n_i;
      idx_fall = hole_prev_reg && !hole_pulse_n_i;
      is_read = cmd[0][4:0] == `FRDS_OP_READ || cmd[0][4:0] == `FRDS_OP_READ_DEL;
      deleted_op = cmd[0][4:0] == `FRDS_OP_READ_DEL;
      cm_hit = dam_deleted_i ^ deleted_op;
      start_head = 1'b0;
      do_advance = 1'b0;
      case (state_reg)
         st_idle:
         begin
            if (head_reg)
            begin
               if (timer_reg == 17'h00000)
                  head_next = 1'b0;
               else
                  timer_next = timer_reg - 17'h00001;
            end
            if (cmd_ready)
            begin
               busy_next = 1'b1;
               c_next = cmd[2];
               h_next = cmd[3];
               r_next = cmd[4];
               {ic_next, se_next, en_next, de_next, nd_next} = 6'h00;
               {cm_next, dd_next, cm_stop_next, stopped_next, matched_next} = 5'h00;
               res_next = 3'h0;
               if (!is_read)
               begin
                  ic_next = `FRDS_IC_INVALID;
                  state_next = st_result;
               end
               else if (implied_seek_en_i)
               begin
                  seek_req_next = 1'b1;
                  dbusy_next[cmd[1][1:0]] = 1'b1;
                  state_next = st_seek;
               end
               else
               begin
                  start_head = 1'b1;
               end
            end
         end
         st_seek:
         begin
            if (seek_fail_i)
            begin
               dbusy_next = 4'h0;
               ic_next = `FRDS_IC_ABNORMAL;
               se_next = 1'b1;
               c_next = seek_fail_cyl_i;
               state_next = st_result;
            end
            else if (seek_done_i)
            begin
               dbusy_next = 4'h0;
               start_head = 1'b1;
            end
         end
         st_settle:
         begin
            if (timer_reg == 17'h00000)
               state_next = st_scan;
            else
               timer_next = timer_reg - 17'h00001;
         end
         st_scan:
         begin
            if (idx_fall)
            begin
               idx_next = idx_reg + 2'h1;
               if (idx_reg == 2'h1)
               begin
                  ic_next = `FRDS_IC_ABNORMAL;
                  nd_next = 1'b1;
                  state_next = st_result;
               end
            end
            if (id_valid_i)
            begin
               if (!id_crc_ok_i)
               begin
                  ic_next = `FRDS_IC_ABNORMAL;
                  de_next = 1'b1;
                  dd_next = 1'b1;
                  state_next = st_result;
               end
               else
               begin
                  matched_next = id_cyl_i == c_reg && id_head_i == h_reg &&
                                 id_sector_i == r_reg && id_size_i == cmd[5];
               end
            end
            else if (dam_valid_i && matched_reg)
            begin
               matched_next = 1'b0;
               if (cm_hit)
                  cm_next = 1'b1;
               if (cm_hit && cmd[0][`FRDS_B0_SK])
               begin
                  do_advance = 1'b1;
               end
               else
               begin
                  cm_stop_next = cm_hit;
                  state_next = st_data;
               end
            end
         end
         st_data:
         begin
            if (disk_byte_valid_i && deliver && !stopped_reg)
            begin
               if (fifo_free)
               begin
                  fv_next = 1'b1;
                  fd_next = disk_byte_i;
                  fres_next = 1'b0;
               end
               else
               begin
                  stopped_next = 1'b1;
               end
            end
            if (transfer_stop_i)
               stopped_next = 1'b1;
            if (last_byte)
               state_next = st_crc;
         end
         st_crc:
         begin
            if (data_crc_valid_i)
            begin
               if (!data_crc_ok_i)
               begin
                  ic_next = `FRDS_IC_ABNORMAL;
                  de_next = 1'b1;
                  state_next = st_result;
               end
               else if (cm_stop_reg)
               begin
                  state_next = st_result;
               end
               else
               begin
                  do_advance = 1'b1;
               end
            end
         end
         st_result:
         begin
            if (fifo_free)
            begin
               fv_next = 1'b1;
               fres_next = 1'b1;
               fd_next = result_byte(res_reg, st0, st1, st2, c_reg, h_reg, r_reg, cmd[5]);
               res_next = res_reg + 3'h1;
               if (res_reg == `FRDS_RES_BYTES - 3'h1)
               begin
                  busy_next = 1'b0;
                  timer_next = 17'(unload_time_i) * 17'(TICK_CYCLES);
                  state_next = st_idle;
               end
            end
         end
         default:
         begin
            state_next = st_idle;
         end
      endcase
      if (start_head)
      begin
         idx_next = 2'h0;
         if (head_reg)
         begin
            // The unload count may run out in this very cycle; the new command keeps the head.
            head_next = 1'b1;
            state_next = st_scan;
         end
         else
         begin
            head_next = 1'b1;
            timer_next = 17'(settle_time_i) * 17'(TICK_CYCLES);
            state_next = st_settle;
         end
      end
      if (do_advance)
      begin
         idx_next = 2'h0;
         state_next = stopped_reg ? st_result : st_scan;
         if (r_reg == cmd[6])
         begin
            r_next = 8'h01;
            if (cmd[0][`FRDS_B0_MT])
               h_next = {h_reg[7:1], !h_reg[0]};
            if (cmd[0][`FRDS_B0_MT] && !h_reg[0])
            begin
               state_next = stopped_reg ? st_result : st_scan;
            end
            else
            begin
               c_next = c_reg + 8'h01;
               state_next = st_result;
               if (!stopped_reg)
               begin
                  ic_next = `FRDS_IC_ABNORMAL;
                  en_next = 1'b1;
               end
            end
         end
         else
         begin
            r_next = r_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_reg <= st_idle;
         c_reg <= 8'h00;
         h_reg <= 8'h00;
         r_reg <= 8'h00;
         {ic_reg, idx_reg} <= 4'h0;
         {se_reg, en_reg, de_reg, nd_reg, cm_reg, dd_reg} <= 6'h00;
         {matched_reg, cm_stop_reg, stopped_reg} <= 3'h0;
         hole_prev_reg <= 1'b1;
         timer_reg <= 17'h00000;
         res_reg <= 3'h0;
         {seek_req_reg, busy_reg, head_reg} <= 3'h0;
         dbusy_reg <= 4'h0;
         {fv_reg, fres_reg} <= 2'h0;
         fd_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         c_reg <= c_next;
         h_reg <= h_next;
         r_reg <= r_next;
         {ic_reg, idx_reg} <= {ic_next, idx_next};
         {se_reg, en_reg, de_reg, nd_reg, cm_reg, dd_reg} <=
            {se_next, en_next, de_next, nd_next, cm_next, dd_next};
         {matched_reg, cm_stop_reg, stopped_reg} <= {matched_next, cm_stop_next, stopped_next};
         hole_prev_reg <= hole_prev_next;
         timer_reg <= timer_next;
         res_reg <= res_next;
         {seek_req_reg, busy_reg, head_reg} <= {seek_req_next, busy_next, head_next};
         dbusy_reg <= dbusy_next;
         {fv_reg, fres_reg} <= {fv_next, fres_next};
         fd_reg <= fd_next;
      end
   end

   assign seek_req_o = seek_req_reg;
   assign seek_cyl_o = c_reg;
   assign drive_busy_o = dbusy_reg;
   assign head_load_o = head_reg;
   assign cmd_busy_o = busy_reg;
   assign fifo_valid_o = fv_reg;
   assign fifo_data_o = fd_reg;
   assign fifo_result_o = fres_reg;

   ////////////////////////////////////////////////////////////////////////////////
   property p_seek_busy;
      @(posedge clk_sys_i) disable iff (rst_i)
      state_reg == st_seek |-> drive_busy_o[cmd[1][1:0]];
   endproperty
   a_seek_busy: assert property (p_seek_busy) else $error("Drive not busy in seek.");

   property p_seek_fail;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == st_seek && seek_fail_i) |=> ic_reg == 2'h1 && c_reg == $past(seek_fail_cyl_i);
   endproperty
   a_seek_fail: assert property (p_seek_fail) else $error("Seek failure not reported.");

   property p_settle_head;
      @(posedge clk_sys_i) disable iff (rst_i)
      state_reg == st_settle |-> head_load_o;
   endproperty
   a_settle_head: assert property (p_settle_head) else $error("Settling with head unloaded.");

   property p_loaded_skip;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == st_idle && cmd_ready && is_read && !implied_seek_en_i && head_reg)
         |=> state_reg == st_scan;
   endproperty
   a_loaded_skip: assert property (p_loaded_skip) else $error("Loaded head settled again.");

   property p_index_twice;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == st_scan && idx_fall && idx_reg == 2'h1) |=> state_reg == st_result && nd_reg;
   endproperty
   a_index_twice: assert property (p_index_twice) else $error("Missing sector not flagged.");

   property p_id_crc;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == st_scan && id_valid_i && !id_crc_ok_i) |=> de_reg && dd_reg && ic_reg == 2'h1;
   endproperty
   a_id_crc: assert property (p_id_crc) else $error("ID CRC fault not flagged.");

   property p_stop_quiet;
      @(posedge clk_sys_i) disable iff (rst_i)
      (stopped_reg && state_reg == st_data) |=> !(fv_reg && !fres_reg && $changed(fd_reg));
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("Data passed after stop.");

   property p_result_end;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == st_result && fifo_free && res_reg == 3'h6) |=> state_reg == st_idle && fres_reg;
   endproperty
   a_result_end: assert property (p_result_end) else $error("Result length wrong.");

   property p_wrap;
      @(posedge clk_sys_i) disable iff (rst_i)
      (do_advance && r_reg == cmd[6]) |=> r_reg == 8'h01;
   endproperty
   a_wrap: assert property (p_wrap) else $error("Sector did not wrap to one.");
endmodule

// ### rtl/frds_defs.svh
// Constants of the floppy read data sequencer: opcodes, fields, result bits and timing.
`ifndef FRDS_DEFS_SVH
`define FRDS_DEFS_SVH

`define FRDS_CMD_BYTES 4'h9
`define FRDS_RES_BYTES 3'h7
`define FRDS_OP_READ 5'h06
`define FRDS_OP_READ_DEL 5'h0c
`define FRDS_B0_MT 7
`define FRDS_B0_SK 5
`define FRDS_B1_HEAD 2
`define FRDS_IC_NORMAL 2'h0
`define FRDS_IC_ABNORMAL 2'h1
`define FRDS_IC_INVALID 2'h2
`define FRDS_ST0_SE 5
`define FRDS_ST0_HEAD 2
`define FRDS_ST1_EN 7
`define FRDS_ST1_DE 5
`define FRDS_ST1_ND 2
`define FRDS_ST2_CM 6
`define FRDS_ST2_DD 5
`define FRDS_BASE_SECTOR 15'h0080
`define FRDS_SHORT_LIMIT 8'h80
`define FRDS_CLK_NS 5
`define FRDS_TICK_NS 1000
`define FRDS_TICK_CYCLES ((`FRDS_TICK_NS) / (`FRDS_CLK_NS))

`endif

// ### rtl/frds_pkg.sv
// Types shared by the floppy read data sequencer modules.
package frds_pkg;
   typedef logic [7:0] frds_byte_t;
   typedef logic [14:0] frds_count_t;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_seek = 3'b001,
      st_settle = 3'b010,
      st_scan = 3'b011,
      st_data = 3'b100,
      st_crc = 3'b101,
      st_result = 3'b110
   } frds_state_t;
endpackage

// ### rtl/frds_cmd_loader.sv
// Collects the nine command bytes of a data transfer command.
`timescale 1ns/1ps
`include "frds_defs.svh"
module frds_cmd_loader (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic busy_i,
   input wire logic cmd_valid_i,
   input wire frds_pkg::frds_byte_t cmd_byte_i,
   output logic cmd_ready_o,
   output frds_pkg::frds_byte_t cmd_o [0:8]
);
   import frds_pkg::*;

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic ready_reg;
   logic ready_next;
   frds_byte_t bytes_reg [0:8];
   frds_byte_t bytes_next [0:8];

   always_comb
   begin
      cnt_next = cnt_reg;
      ready_next = 1'b0;
      bytes_next = bytes_reg;
      if (cmd_valid_i && !busy_i)
      begin
         bytes_next[cnt_reg] = cmd_byte_i;
         if (cnt_reg == `FRDS_CMD_BYTES - 4'h1)
         begin
            cnt_next = 4'h0;
            ready_next = 1'b1;
         end
         else
         begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= 4'h0;
         ready_reg <= 1'b0;
         for (int i = 0; i < 9; i++)
         begin
            bytes_reg[i] <= 8'h00;
         end
      end
      else
      begin
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
         bytes_reg <= bytes_next;
      end
   end

   assign cmd_ready_o = ready_reg;
   assign cmd_o = bytes_reg;

   property p_ninth_byte;
      @(posedge clk_sys_i) disable iff (rst_i)
      cmd_ready_o |-> $past(cnt_reg) == 4'h8 && $past(cmd_valid_i) && cnt_reg == 4'h0;
   endproperty
   a_ninth_byte: assert property (p_ninth_byte) else $error("Start without nine bytes.");
endmodule

// ### rtl/frds_sector_counter.sv
// Counts bytes within one sector and decides which of them reach the host.
`timescale 1ns/1ps
`include "frds_defs.svh"
module frds_sector_counter (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic byte_i,
   input wire logic [2:0] size_code_i,
   input wire frds_pkg::frds_byte_t short_len_i,
   output logic deliver_o,
   output logic last_o,
   output logic beyond_short_o
);
   import frds_pkg::*;

   frds_count_t cnt_reg;
   frds_count_t cnt_next;
   frds_count_t size;
   frds_count_t limit;

   function automatic frds_count_t sector_bytes(input logic [2:0] code);
      sector_bytes = `FRDS_BASE_SECTOR << code;
   endfunction

   always_comb
   begin
      size = sector_bytes(size_code_i);
      limit = size;
      if (size_code_i == 3'h0 && short_len_i < `FRDS_SHORT_LIMIT)
      begin
         limit = {7'h00, short_len_i};
      end
      cnt_next = clear_i ? 15'h0000 : (byte_i ? cnt_reg + 15'h0001 : cnt_reg);
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         cnt_reg <= 15'h0000;
      else
         cnt_reg <= cnt_next;
   end

   assign deliver_o = cnt_reg < limit;
   assign last_o = byte_i && cnt_reg == size - 15'h0001;
   // A write path fills these positions with zero bytes; a read discards them.
   assign beyond_short_o = !deliver_o;

   property p_short_limit;
      @(posedge clk_sys_i) disable iff (rst_i)
      (size_code_i == 3'h0 && short_len_i < 8'h80 && deliver_o) |-> cnt_reg < 15'(short_len_i);
   endproperty
   a_short_limit: assert property (p_short_limit) else $error("Short sector overrun.");

   property p_full_sector;
      @(posedge clk_sys_i) disable iff (rst_i)
      last_o |-> cnt_reg == (15'h0080 << size_code_i) - 15'h0001;
   endproperty
   a_full_sector: assert property (p_full_sector) else $error("Sector length wrong.");
endmodule

// ### dv/frds_disk_model.sv
// Behavioural floppy drive: a spinning track of 128-byte sectors and a seek responder.
`timescale 1ns/1ps
module frds_disk_model #(
   parameter int SECS = 4
) (
   input wire logic clk_sys_i,
   input wire logic seek_req_i,
   input wire logic [7:0] del_r_i,
   output logic seek_done_o,
   output logic hole_pulse_n_o,
   output logic id_valid_o,
   output logic [7:0] id_cyl_o,
   output logic [7:0] id_head_o,
   output logic [7:0] id_sector_o,
   output logic [7:0] id_size_o,
   output logic dam_valid_o,
   output logic dam_deleted_o,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic crc_valid_o
);
   logic [3:0] seek_sh = 4'h0;
   int r;
   int i;
   int s;
   assign id_cyl_o = 8'h05;
   assign id_size_o = 8'h00;
   assign seek_done_o = seek_sh[3];
   always @(posedge clk_sys_i) seek_sh <= {seek_sh[2:0], seek_req_i};
   // The track turns whether or not the head is loaded, as a real spindle does.
   initial
   begin
      {id_valid_o, dam_valid_o, dam_deleted_o, byte_valid_o, crc_valid_o} = '0;
      hole_pulse_n_o = 1'b1;
      id_sector_o = 8'h00;
      id_head_o = 8'h00;
      byte_o = 8'h00;
      forever
      begin
         // Side zero passes first, then side one, so each side is met once a turn.
         for (r = 1; r <= 2 * SECS; r++)
         begin
            s = (r - 1) % SECS + 1;
            @(posedge clk_sys_i) id_sector_o <= 8'(s);
            id_head_o <= 8'(r > SECS);
            id_valid_o <= 1'b1;
            @(posedge clk_sys_i) id_valid_o <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            dam_deleted_o <= (8'(s) == del_r_i);
            dam_valid_o <= 1'b1;
            @(posedge clk_sys_i) dam_valid_o <= 1'b0;
            for (i = 0; i < 128; i++)
            begin
               repeat (7) @(posedge clk_sys_i);
               byte_o <= 8'(s) ^ 8'(i);
               byte_valid_o <= 1'b1;
               // A released data line shows the inverse so stale values never pass.
               @(posedge clk_sys_i) byte_valid_o <= 1'b0;
               byte_o <= ~byte_o;
            end
            @(posedge clk_sys_i) crc_valid_o <= 1'b1;
            @(posedge clk_sys_i) crc_valid_o <= 1'b0;
         end
         @(posedge clk_sys_i) hole_pulse_n_o <= 1'b0;
         @(posedge clk_sys_i) hole_pulse_n_o <= 1'b1;
      end
   end
endmodule

// ### dv/test_frds_read_seq.sv
// Self-checking bench of the read data sequencer against a behavioural drive.
`timescale 1ns/1ps
module test_frds_read_seq;
   import frds_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   frds_byte_t cmd_byte_i = 8'h00;
   logic seek_en = 1'b1;
   logic stop = 1'b0;
   logic rdy = 1'b1;
   logic [7:0] del_r = 8'h00;
   logic fail = 1'b0;
   logic seek_fail = 1'b0;
   logic seek_req, seek_done, hole_n, id_v, dam_v, dam_del, byte_v, crc_v, f_v, f_res, head, busy;
   frds_byte_t seek_cyl, id_c, id_h, id_r, id_n, d_byte, f_data, short_sector_length, fcyl;
   logic [3:0] busy4;
   frds_byte_t res [0:6];
   int error_cnt = 0;
   int checks = 0;
   int seed = 32'h85fba859;
   int nres, ndat, sec, len, stop_at, eot_g;
   frds_read_seq #(.TICK_CYCLES(2)) i_frds_read_seq (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .implied_seek_en_i(seek_en),
      .settle_time_i(8'h03), .unload_time_i(8'h40), .seek_req_o(seek_req), .seek_cyl_o(seek_cyl),
      .seek_done_i(seek_done), .seek_fail_i(seek_fail), .seek_fail_cyl_i(fcyl), .drive_busy_o(busy4),
      .head_load_o(head), .cmd_busy_o(busy), .hole_pulse_n_i(hole_n), .id_valid_i(id_v),
      .id_cyl_i(id_c), .id_head_i(id_h), .id_sector_i(id_r), .id_size_i(id_n), .id_crc_ok_i(1'b1),
      .dam_valid_i(dam_v), .dam_deleted_i(dam_del), .disk_byte_valid_i(byte_v),
      .disk_byte_i(d_byte), .data_crc_valid_i(crc_v), .data_crc_ok_i(1'b1),
      .transfer_stop_i(stop), .fifo_valid_o(f_v), .fifo_data_o(f_data), .fifo_result_o(f_res),
      .fifo_ready_i(rdy));
   frds_disk_model i_frds_disk_model (.clk_sys_i(clk_sys_i), .seek_req_i(seek_req),
      .del_r_i(del_r), .seek_done_o(seek_done), .hole_pulse_n_o(hole_n), .id_valid_o(id_v),
      .id_cyl_o(id_c), .id_head_o(id_h), .id_sector_o(id_r), .id_size_o(id_n),
      .dam_valid_o(dam_v), .dam_deleted_o(dam_del), .byte_valid_o(byte_v), .byte_o(d_byte),
      .crc_valid_o(crc_v));
   always #2.5 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input frds_byte_t seen, input frds_byte_t exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // The host stalls at random; a byte every eight cycles keeps overrun out of plain runs.
   always @(posedge clk_sys_i)
   begin
      rdy <= ($random(seed) & 7) != 0;
      seek_fail <= fail && seek_req;
      if (seek_req)
      begin
         check(seek_cyl, 8'h05);
         check(8'(busy4), 8'h01);
      end
      if (f_v && rdy && f_res && nres < 7)
      begin
         check(8'(busy), 8'(nres < 6));
         res[nres] = f_data;
         nres++;
      end
      else if (f_v && rdy && !f_res)
      begin
         check(f_data, frds_byte_t'(sec) ^ frds_byte_t'(ndat % len));
         check(8'(head), 8'h01);
         ndat++;
         if (ndat % len == 0)
            sec = (sec == eot_g) ? 1 : sec + 1;
         if (ndat == stop_at)
            stop <= 1'b1;
      end
   end
   task automatic run(input frds_byte_t b0, r, last_sector_number, dl, d, input int sa, n, nc,
      input logic [55:0] e);
      frds_byte_t c [0:8];
      c = '{b0, 8'h00, 8'h05, 8'h00, r, 8'h00, last_sector_number, 8'h1b, dl};
      nres = 0;
      ndat = 0;
      sec = r;
      eot_g = last_sector_number;
      len = (dl < 8'h80) ? dl : 128;
      stop_at = sa;
      del_r = d;
      foreach (res[j])
         res[j] = 'x;
      @(posedge clk_sys_i);
      stop <= 1'b0;
      seek_en <= fail | $random(seed);
      for (int i = 0; i < 9; i++)
      begin
         cmd_byte_i <= c[i];
         cmd_valid_i <= 1'b1;
         @(posedge clk_sys_i);
      end
      cmd_valid_i <= 1'b0;
      for (int i = 0; i < 20000 && nres < 7; i++)
         @(posedge clk_sys_i);
      repeat (4) @(posedge clk_sys_i);
      for (int j = 0; j < nc; j++)
         check(res[j], e[55 - 8 * j -: 8]);
      if (n >= 0)
         check(frds_byte_t'(ndat), frds_byte_t'(n));
   endtask
   initial
   begin
      short_sector_length = 8'h01 + (frds_byte_t'($random(seed)) & 8'h7e);
      fcyl = frds_byte_t'($random(seed));
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      run(8'h46, 8'h01, 8'h02, short_sector_length, 8'h00, -1, 2 * short_sector_length, 7, 56'h40800006000100);
      run(8'hc6, 8'h02, 8'h02, 8'hff, 8'h00, -1, 384, 7, 56'h40800006000100);
      fail = 1'b1;
      run(8'h46, 8'h01, 8'h02, 8'hff, 8'h00, -1, 0, 7, {24'h600000, fcyl, 24'h000100});
      fail = 1'b0;
      run(8'h46, 8'h03, 8'h04, 8'hff, 8'h00, 10, -1, 7, 56'h00000005000400);
      run(8'h46, 8'h02, 8'h04, 8'hff, 8'h02, -1, 128, 7, 56'h00004005000200);
      run(8'h4c, 8'h01, 8'h01, 8'hff, 8'h01, -1, 128, 7, 56'h40800006000100);
      run(8'h46, 8'h09, 8'h09, 8'hff, 8'h00, -1, 0, 7, 56'h40040005000900);
      run(8'h41, 8'h01, 8'h01, 8'hff, 8'h00, -1, 0, 3, 56'h80000000000000);
      final_report;
   end
   initial
   begin
      #500000;
      error_cnt++;
      final_report;
   end
endmodule
